// ### core/sfp_pkg.sv
// Shared constants and carriers for the flash protocol and status block.
// Assumes one core clock and one serial clock driven by the host.
package sfp_pkg;

	// Line usage of the serial link
	typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

	// Command opcodes
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_RDSR   = 8'h05;
	localparam logic [7:0] OP_WRSR   = 8'h01;
	localparam logic [7:0] OP_WRVCR  = 8'h81;
	localparam logic [7:0] OP_WREVCR = 8'h61;
	localparam logic [7:0] OP_WRNVCR = 8'hB1;
	localparam logic [7:0] OP_PROG   = 8'h02;
	localparam logic [7:0] OP_SECTER = 8'hD8;
	localparam logic [7:0] OP_DIEER  = 8'hC4;
	localparam logic [7:0] OP_CLRFLG = 8'h50;

	// Status field positions
	localparam int SR_BUSY = 0;
	localparam int SR_WEL  = 1;
	localparam int SR_SIDE = 5;
	localparam int SR_BPHI = 6;
	localparam int SR_WDIS = 7;
	localparam logic [7:0] SR_RESET = 8'h00;

	// Configuration field positions
	localparam int NV_DUAL  = 2;
	localparam int NV_QUAD  = 3;
	localparam int NV_DUMMY = 12;
	localparam int EV_B6    = 6;
	localparam int EV_B7    = 7;
	localparam int VC_DUMMY = 4;
	localparam logic [15:0] NVCR_RESET = 16'hFFFF;

	// Array geometry and payload lengths
	localparam int SECT_LSB  = 16;
	localparam int SECT_BITS = 10;
	localparam logic [2:0] PROG_MIN = 3'h5;
	localparam logic [2:0] ADDR_LEN = 3'h4;
	localparam int BUSY_CYCLES_DEF = 16;

	// Hidden working configuration
	typedef struct packed {
		logic [3:0] dummy;
		proto_t     proto;
	} icr_t;

	// Core to link: protocol in force and status snapshot
	typedef struct packed {
		proto_t     proto;
		logic [7:0] status;
	} pub_t;

	// Link to core: last command frame
	typedef struct packed {
		logic            seq;
		logic [7:0]      opcode;
		logic [2:0]      nbytes;
		logic [3:0][7:0] pay;
	} frame_t;

endpackage

// ### core/sfp_regs.sv
// Protocol selection, working configuration and status register logic.
// Assumes a host on sclk/cs_n and a nonvolatile store on the stored ports.

module sfp_regs #(
	parameter int BUSY_CYCLES = sfp_pkg::BUSY_CYCLES_DEF
) (
	input  wire logic           clk,
	input  wire logic           resetn,
	input  wire logic           sclk,
	input  wire logic           cs_n,
	input  wire logic [3:0]     io_in,
	output logic [3:0]          io_out,
	output logic [3:0]          io_oe_n,
	input  wire logic           wp_n,
	input  wire logic           vpp_hi,
	input  wire logic [15:0]    nvcr_stored,
	input  wire logic [7:2]     sr_nv_stored,
	output logic [7:0]          status_out,
	output logic [15:0]         nvcr_out,
	output sfp_pkg::icr_t       icr_out,
	output sfp_pkg::proto_t     proto_out,
	output logic                pe_ready
);
	import sfp_pkg::*;

	generate
		if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_chk
			$error("BUSY_CYCLES out of range");
		end
	endgenerate

	typedef enum {ST_BOOT, ST_IDLE, ST_BUSY} cst_t;

	typedef struct packed {
		logic        cs_s1, cs_s2, cs_q;
		logic        wp_s1, wp_s2;
		logic        vp_s1, vp_s2;
		logic        seq_done;
		logic        perr;
		cst_t        st;
		logic [15:0] cnt;
		logic [7:0]  status;
		logic [15:0] nvcr;
		icr_t        icr;
		pub_t        pub;
	} core_t;

	typedef struct packed {
		logic       have_op;
		logic       rd_stat;
		logic [3:0] bcnt;
		logic [7:0] sh;
		logic [7:0] out_sh;
	} link_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe_n;
	} drv_t;

	core_t  c_r, c_nxt;
	link_t  l_r, l_nxt;
	frame_t f_r, f_nxt;
	drv_t   d_r, d_nxt;

	// Bits carried per serial edge in each protocol
	function automatic logic [3:0] lanes(input proto_t p);
		case (p)
			PROTO_DUAL: lanes = 4'h2;
			PROTO_QUAD: lanes = 4'h4;
			default:    lanes = 4'h1;
		endcase
	endfunction

	// Boot protocol from nonvolatile bits, quad first
	function automatic proto_t nv_proto(input logic [15:0] nv);
		if (!nv[NV_QUAD])
			nv_proto = PROTO_QUAD;
		else if (!nv[NV_DUAL])
			nv_proto = PROTO_DUAL;
		else
			nv_proto = PROTO_EXT;
	endfunction

	// Protocol chosen by an enhanced volatile write
	function automatic proto_t ev_proto(input logic [7:0] b);
		if (!b[EV_B7])
			ev_proto = PROTO_QUAD;
		else if (!b[EV_B6])
			ev_proto = PROTO_DUAL;
		else
			ev_proto = PROTO_EXT;
	endfunction

	// Sector falls inside the protected region
	function automatic logic prot_hit(input logic [SECT_BITS-1:0] sec,
		input logic [3:0] bp, input logic side);
		logic [10:0] n;
		n = 11'h000;
		if (bp >= 4'hB)
			n = 11'h400;
		else if (bp != 4'h0)
			n = 11'(11'h001 << (bp - 4'h1));
		if (side)
			prot_hit = {1'b0, sec} < n;
		else
			prot_hit = {1'b0, sec} >= (11'h400 - n);
	endfunction

	logic       frame_rst;
	logic [3:0] w;
	logic [7:0] byte_in;
	logic       byte_done;
	proto_t     eff_proto;
	logic       exec;
	logic [3:0] bp;
	logic       wel;
	logic [SECT_BITS-1:0] sect;
	logic [15:0] addr_hi;

	assign frame_rst = cs_n | ~resetn;
	assign w = lanes(c_r.pub.proto);

	// Incoming bits: line zero only when extended
	always_comb begin
		l_nxt = l_r;
		f_nxt = f_r;
		byte_in = 8'h00;
		case (c_r.pub.proto)
			PROTO_DUAL: byte_in = {l_r.sh[5:0], io_in[1:0]};
			PROTO_QUAD: byte_in = {l_r.sh[3:0], io_in[3:0]};
			default:    byte_in = {l_r.sh[6:0], io_in[0]};
		endcase
		byte_done = (l_r.bcnt + w) == 4'h8;
		l_nxt.sh = byte_in;
		l_nxt.bcnt = byte_done ? 4'h0 : l_r.bcnt + w;
		if (byte_done && !l_r.have_op) begin
			l_nxt.have_op = 1'b1;
			f_nxt.opcode = byte_in;
			f_nxt.nbytes = 3'h0;
			f_nxt.seq = ~f_r.seq;
			if (byte_in == OP_RDSR) begin
				l_nxt.rd_stat = 1'b1;
				l_nxt.out_sh = c_r.pub.status;
			end
		end else if (byte_done) begin
			if (f_r.nbytes < 3'h4)
				f_nxt.pay[f_r.nbytes[1:0]] = byte_in;
			if (f_r.nbytes != 3'h7)
				f_nxt.nbytes = f_r.nbytes + 3'h1;
		end
		// Status repeats for as long as the host clocks
		if (l_r.rd_stat) begin
			case (c_r.pub.proto)
				PROTO_DUAL: l_nxt.out_sh = {l_r.out_sh[5:0], l_r.out_sh[7:6]};
				PROTO_QUAD: l_nxt.out_sh = {l_r.out_sh[3:0], l_r.out_sh[7:4]};
				default:    l_nxt.out_sh = {l_r.out_sh[6:0], l_r.out_sh[7]};
			endcase
		end
	end

	// Frame counters die with chip select; sclk may stop outside frames
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst)
			l_r <= '0;
		else
			l_r <= l_nxt;
	end

	// Frame record must outlive chip select so the core can read it
	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn)
			f_r <= '0;
		else
			f_r <= f_nxt;
	end

	// Output lanes, extended answers on line one
	always_comb begin
		d_nxt.out = 4'h0;
		d_nxt.oe_n = 4'hF;
		if (l_r.rd_stat) begin
			case (c_r.pub.proto)
				PROTO_DUAL: begin
					d_nxt.out = {2'b00, l_r.out_sh[7:6]};
					d_nxt.oe_n = 4'hC;
				end
				PROTO_QUAD: begin
					d_nxt.out = l_r.out_sh[7:4];
					d_nxt.oe_n = 4'h0;
				end
				default: begin
					d_nxt.out = {2'b00, l_r.out_sh[7], 1'b0};
					d_nxt.oe_n = 4'hD;
				end
			endcase
		end
	end

	// Drive on the falling edge so the host samples on the rising one
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst)
			d_r <= '{out: 4'h0, oe_n: 4'hF};
		else
			d_r <= d_nxt;
	end

	assign io_out = d_r.out;
	assign io_oe_n = d_r.oe_n;

	assign bp = {c_r.status[SR_BPHI], c_r.status[4:2]};
	assign wel = c_r.status[SR_WEL];
	// First two address bytes hold address bits 31:16, MSB first
	assign addr_hi = {f_r.pay[0], f_r.pay[1]};
	assign sect = addr_hi[SECT_LSB-16+SECT_BITS-1:SECT_LSB-16];
	assign exec = c_r.cs_s2 && !c_r.cs_q && (f_r.seq != c_r.seq_done);

	// Quad falls back while a Vpp-assisted write runs
	always_comb begin
		if (c_r.icr.proto == PROTO_QUAD && c_r.status[SR_BUSY] && c_r.vp_s2)
			eff_proto = PROTO_EXT;
		else
			eff_proto = c_r.icr.proto;
	end

	// Core: command execution at frame end, busy timer, boot load
	always_comb begin
		c_nxt = c_r;
		c_nxt.cs_s1 = cs_n;
		c_nxt.cs_s2 = c_r.cs_s1;
		c_nxt.cs_q = c_r.cs_s2;
		c_nxt.wp_s1 = wp_n;
		c_nxt.wp_s2 = c_r.wp_s1;
		c_nxt.vp_s1 = vpp_hi;
		c_nxt.vp_s2 = c_r.vp_s1;
		if (exec)
			c_nxt.seq_done = f_r.seq;
		case (c_r.st)
			ST_BOOT: begin
				c_nxt.nvcr = nvcr_stored;
				c_nxt.status = {sr_nv_stored, 2'b00};
				c_nxt.icr.proto = nv_proto(nvcr_stored);
				c_nxt.icr.dummy = nvcr_stored[NV_DUMMY+:4];
				c_nxt.st = ST_IDLE;
			end
			ST_IDLE: begin
				if (exec) begin
					case (f_r.opcode)
						OP_WREN: c_nxt.status[SR_WEL] = 1'b1;
						OP_WRDI: if (!c_r.perr) c_nxt.status[SR_WEL] = 1'b0;
						OP_CLRFLG: begin
							c_nxt.perr = 1'b0;
							c_nxt.status[SR_WEL] = 1'b0;
						end
						OP_WRVCR: if (f_r.nbytes != 3'h0)
							c_nxt.icr.dummy = f_r.pay[0][VC_DUMMY+:4];
						OP_WREVCR: if (f_r.nbytes != 3'h0)
							c_nxt.icr.proto = ev_proto(f_r.pay[0]);
						OP_WRSR: begin
							if (wel && f_r.nbytes != 3'h0
								&& !(c_r.status[SR_WDIS] && !c_r.wp_s2)) begin
								c_nxt.status[7:2] = f_r.pay[0][7:2];
								c_nxt.st = ST_BUSY;
							end
						end
						OP_WRNVCR: begin
							if (wel && f_r.nbytes >= 3'h2) begin
								c_nxt.nvcr = {f_r.pay[1], f_r.pay[0]};
								c_nxt.st = ST_BUSY;
							end
						end
						OP_PROG, OP_SECTER: begin
							if (wel && f_r.nbytes >= ((f_r.opcode == OP_PROG) ?
								PROG_MIN : ADDR_LEN)) begin
								if (prot_hit(sect, bp, c_r.status[SR_SIDE]))
									c_nxt.perr = 1'b1;
								else
									c_nxt.st = ST_BUSY;
							end
						end
						OP_DIEER: begin
							if (wel) begin
								if (bp != 4'h0)
									c_nxt.perr = 1'b1;
								else
									c_nxt.st = ST_BUSY;
							end
						end
						default: c_nxt.perr = c_r.perr;
					endcase
					if (c_nxt.st == ST_BUSY) begin
						c_nxt.status[SR_BUSY] = 1'b1;
						c_nxt.cnt = 16'(BUSY_CYCLES);
					end
				end
			end
			ST_BUSY: begin
				c_nxt.cnt = c_r.cnt - 16'h0001;
				if (c_r.cnt == 16'h0001) begin
					c_nxt.status[SR_BUSY] = 1'b0;
					c_nxt.status[SR_WEL] = 1'b0;
					c_nxt.st = ST_IDLE;
				end
			end
			default: c_nxt.st = ST_BOOT;
		endcase
		if (c_nxt.perr)
			c_nxt.status[SR_WEL] = 1'b1;
		// Snapshot only between frames; a poll within one frame sees no update
		if (c_r.cs_s2)
			c_nxt.pub = '{proto: eff_proto, status: c_nxt.status};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			c_r <= '{st: ST_BOOT, status: SR_RESET, nvcr: NVCR_RESET,
				cs_s1: 1'b1, cs_s2: 1'b1, cs_q: 1'b1, default: '0};
		else
			c_r <= c_nxt;
	end

	assign status_out = c_r.status;
	assign nvcr_out = c_r.nvcr;
	assign icr_out = c_r.icr;
	assign proto_out = c_r.pub.proto;
	assign pe_ready = ~c_r.status[SR_BUSY];

	a_ready_inv: assert property (@(posedge clk) disable iff (!resetn)
		pe_ready == !status_out[SR_BUSY]) else $error("ready not inverse of busy");
	a_quad_sel: assert property (@(posedge clk) disable iff (!resetn)
		exec && c_r.st == ST_IDLE && f_r.opcode == OP_WREVCR && f_r.nbytes != 3'h0
		&& !f_r.pay[0][EV_B7] |=> c_r.icr.proto == PROTO_QUAD)
		else $error("quad not selected");
	a_dual_sel: assert property (@(posedge clk) disable iff (!resetn)
		exec && c_r.st == ST_IDLE && f_r.opcode == OP_WREVCR && f_r.nbytes != 3'h0
		&& f_r.pay[0][7:6] == 2'b10 |=> c_r.icr.proto == PROTO_DUAL)
		else $error("dual not selected");
	a_boot_load: assert property (@(posedge clk) disable iff (!resetn)
		c_r.st == ST_BOOT |=> c_r.icr.proto == nv_proto($past(nvcr_stored))
		&& c_r.nvcr == $past(nvcr_stored)) else $error("boot config not loaded");
	a_vol_clear: assert property (@(posedge clk) disable iff (!resetn)
		c_r.st == ST_BOOT |-> status_out[1:0] == 2'b00) else $error("volatile bits set");
	a_wp_lock: assert property (@(posedge clk) disable iff (!resetn)
		exec && c_r.st == ST_IDLE && f_r.opcode == OP_WRSR && c_r.status[SR_WDIS] && !c_r.wp_s2
		|=> c_r.status[7:2] == $past(c_r.status[7:2]) && !c_r.status[SR_BUSY])
		else $error("locked status written");
	a_wel_gate: assert property (@(posedge clk) disable iff (!resetn)
		exec && c_r.st == ST_IDLE && !wel |=> !c_r.status[SR_BUSY])
		else $error("write taken without latch");
	a_die_refuse: assert property (@(posedge clk) disable iff (!resetn)
		exec && c_r.st == ST_IDLE && wel && f_r.opcode == OP_DIEER && bp != 4'h0
		|=> !c_r.status[SR_BUSY] ##1 wel)
		else $error("die erase not refused");
	a_err_hold: assert property (@(posedge clk) disable iff (!resetn)
		c_r.perr && !(exec && f_r.opcode == OP_CLRFLG) |=> c_r.perr && wel)
		else $error("error latch lost");
	a_busy_span: assert property (@(posedge clk) disable iff (!resetn)
		$rose(c_r.status[SR_BUSY]) |-> c_r.st == ST_BUSY && c_r.cnt == 16'(BUSY_CYCLES))
		else $error("busy span wrong");
	a_vpp_ext: assert property (@(posedge clk) disable iff (!resetn)
		c_r.cs_s2 && c_r.icr.proto == PROTO_QUAD && c_r.status[SR_BUSY] && c_r.vp_s2
		|=> c_r.pub.proto == PROTO_EXT) else $error("quad kept under Vpp");

endmodule

// ### verification/spi_host_model.sv
// Serial host model: clock idles low, one frame per call.
// Assumes the bench never overlaps two calls.
module spi_host_model (
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import sfp_pkg::*;

	// Idle: deselected, clock still
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'hA;
	end

	// Send nbits MSB first, highest lane first; answer taken on rises
	task automatic xfer(input proto_t p, input logic [39:0] sh, input int nbits,
		output logic [7:0] rd);
		int w;
		w = (p == PROTO_QUAD) ? 4 : (p == PROTO_DUAL) ? 2 : 1;
		rd = 8'h00;
		cs_n = 1'b0;
		#10;
		for (int i = 0; i < nbits / w; i++) begin
			for (int j = w - 1; j >= 0; j--) begin
				io_in[j] = sh[39];
				sh = sh << 1;
			end
			if (w == 1)
				io_in[3:1] = ~io_in[3:1]; // Unused lanes wander
			#7.5 sclk = 1'b1;
			if (i >= 8 / w)
				rd = (w == 1) ? {rd[6:0], io_out[1]} :
					(w == 2) ? {rd[5:0], io_out[1:0]} : {rd[3:0], io_out};
			#7.5 sclk = 1'b0;
		end
		#10 cs_n = 1'b1;
		io_in = ~io_in; // Released lanes must not keep their last level
	endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the protocol and status block.
// Assumes the host model drives the link; busy time lengthened to 40 clocks.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sfp_pkg::*;

	localparam int BUSY_N = 40;
	logic        clk, resetn, sclk, cs_n, wp_n, vpp_hi, pe_ready;
	logic [3:0]  io_in, io_out, io_oe_n;
	logic [15:0] nvcr_stored, nvcr_out, nv;
	logic [7:2]  sr_nv_stored;
	logic [7:0]  status_out, v, rd;
	logic [5:0]  sr;
	logic [31:0] a;
	icr_t        icr_out;
	proto_t      proto_out, cur_p;
	int          mismatches, checks_done, cycles;

	sfp_regs #(.BUSY_CYCLES(BUSY_N)) DUT (.clk(clk), .resetn(resetn), .sclk(sclk),
		.cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .wp_n(wp_n),
		.vpp_hi(vpp_hi), .nvcr_stored(nvcr_stored), .sr_nv_stored(sr_nv_stored),
		.status_out(status_out), .nvcr_out(nvcr_out), .icr_out(icr_out),
		.proto_out(proto_out), .pe_ready(pe_ready));
	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

	// Core clock, 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	// Power-on with given stored contents; reset held 4 cycles
	task automatic boot(input logic [15:0] n, input logic [5:0] s);
		@(posedge clk);
		nvcr_stored <= n;
		sr_nv_stored <= s;
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// One command frame, then room for the core to execute it
	task automatic cmd(input logic [7:0] op, input logic [31:0] d = 32'h0, input int nb = 0);
		host.xfer(cur_p, {op, d}, 8 + 8 * nb, rd);
		repeat (8) @(posedge clk);
	endtask

	task automatic rdsr(input logic [7:0] exp);
		host.xfer(cur_p, {OP_RDSR, 32'h0}, 16, rd);
		check(rd, exp);
		repeat (4) @(posedge clk);
		check(io_oe_n, 4'hF);
	endtask

	// Bounded wait for the end of a write cycle
	task automatic wait_ready();
		int n;
		n = 0;
		while (status_out[0] !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check(status_out[1:0], 2'b00);
	endtask

	task automatic wrsr(input logic [7:0] d);
		cmd(OP_WREN);
		cmd(OP_WRSR, {d, 24'h0}, 1);
		wait_ready();
		check(status_out, {d[7:2], 2'b00});
	endtask

	task automatic evcr(input logic [7:0] d, input proto_t p);
		cmd(OP_WREVCR, {d, 24'h0}, 1);
		cur_p = p;
		check(proto_out, p);
		check(icr_out.proto, p);
		rdsr(8'h00);
	endtask

	initial begin
		void'($urandom(32'h9dcb));
		{resetn, wp_n, vpp_hi} = 3'b010;
		nvcr_stored = 16'hFFFF;
		sr_nv_stored = 6'h00;
		cycles = 0;
		// Boot from each pair of protocol bits, random elsewhere
		for (int k = 0; k < 4; k++) begin
			nv = 16'($urandom);
			nv[3:2] = 2'(k);
			sr = 6'($urandom);
			cur_p = !nv[3] ? PROTO_QUAD : !nv[2] ? PROTO_DUAL : PROTO_EXT;
			boot(nv, sr);
			check(proto_out, cur_p);
			check({icr_out, nvcr_out}, {nv[15:12], cur_p, nv});
			check(status_out, {sr, 2'b00});
			rdsr({sr, 2'b00});
		end
		boot(16'hFFFF, 6'h00);
		cur_p = PROTO_EXT;
		// Cut-short frame, then write refused without the latch
		host.xfer(cur_p, {OP_WREN, 32'h0}, 4, rd);
		repeat (8) @(posedge clk);
		check(status_out, 8'h00);
		cmd(OP_WRSR, {8'h3C, 24'h0}, 1);
		check(status_out, 8'h00);
		cmd(OP_WREN);
		check(status_out, 8'h02);
		v = 8'($urandom) | 8'h80;
		cmd(OP_WRSR, {v, 24'h0}, 1);
		check({status_out, pe_ready}, {v[7:2], 3'b110});
		wait_ready();
		check(pe_ready, 1'b1);
		// Write-disable set and pin low: status locked
		@(posedge clk);
		wp_n <= 1'b0;
		cmd(OP_WREN);
		cmd(OP_WRSR, 32'h0, 1);
		check(status_out, {v[7:2], 2'b10});
		@(posedge clk);
		wp_n <= 1'b1;
		wrsr(8'h04);
		// Die erase with guarded blocks
		cmd(OP_WREN);
		cmd(OP_DIEER);
		check(status_out, 8'h06);
		cmd(OP_WRDI);
		check(status_out, 8'h06);
		cmd(OP_CLRFLG);
		cmd(OP_WRDI);
		check(status_out, 8'h04);
		// Smallest region at top, then at bottom
		for (int s = 0; s < 2; s++) begin
			wrsr({2'b00, 1'(s), 5'b00100});
			a = s ? 32'h0 : 32'h03FF_0000;
			cmd(OP_WREN);
			cmd(OP_SECTER, a, 4);
			check(status_out[1:0], 2'b10);
			cmd(OP_CLRFLG);
			cmd(OP_WREN);
			cmd(OP_SECTER, a ^ 32'h03FF_0000, 4);
			check(status_out[0], 1'b1);
			wait_ready();
		end
		wrsr(8'h00);
		cmd(OP_WREN);
		cmd(OP_DIEER);
		check(status_out[0], 1'b1);
		wait_ready();
		// Nonvolatile image write, low byte first, then a program
		cmd(OP_WREN);
		cmd(OP_WRNVCR, {8'h34, 8'h12, 16'h0}, 2);
		check({nvcr_out, status_out[0]}, {16'h1234, 1'b1});
		wait_ready();
		cmd(OP_WREN);
		cmd(OP_PROG, 32'h0, 5);
		check(status_out[0], 1'b1);
		wait_ready();
		// Volatile protocol changes and dummy count
		v = 8'($urandom);
		evcr({1'b0, v[6:0]}, PROTO_QUAD);
		evcr({2'b10, v[5:0]}, PROTO_DUAL);
		evcr({2'b11, v[5:0]}, PROTO_EXT);
		cmd(OP_WRVCR, {v, 24'h0}, 1);
		check(icr_out.dummy, v[7:4]);
		// High voltage during a quad erase: single-line until it drops
		evcr(8'h7F, PROTO_QUAD);
		@(posedge clk);
		vpp_hi <= 1'b1;
		cmd(OP_WREN);
		cmd(OP_SECTER, 32'h0, 4);
		check({status_out[0], proto_out}, {1'b1, PROTO_EXT});
		@(posedge clk);
		vpp_hi <= 1'b0;
		repeat (5) @(posedge clk);
		check(proto_out, PROTO_QUAD);
		wait_ready();
		boot(16'hFFFF, 6'h00);
		check(proto_out, PROTO_EXT);
		stop_test();
	end
endmodule
